// ==== common/lcdmdc_params.svh ====
// constants for the segment lcd multiplex drive control block
`ifndef LCDMDC_PARAMS_SVH
`define LCDMDC_PARAMS_SVH

// system clock
`define LCDMDC_CLK_KHZ 125000
`define LCDMDC_CLK_MHZ 125

// power-on settle time before the host may talk to the block
`define LCDMDC_POR_WAIT_US 1000

// internal oscillator nominal frequency
`define LCDMDC_OSC_KHZ 200

// frame divisors of the drive clock
`define LCDMDC_FRAME_DIV_NORMAL 12'd2880
`define LCDMDC_FRAME_DIV_SAVE 12'd480

// register byte offsets
`define LCDMDC_REG_MODE 8'h00
`define LCDMDC_REG_BLINK 8'h04
`define LCDMDC_REG_BANK 8'h08
`define LCDMDC_REG_POINTER 8'h0c
`define LCDMDC_REG_DATA 8'h10
`define LCDMDC_REG_STATUS 8'h14

// mode register fields
`define LCDMDC_MODE_DRIVE 1:0
`define LCDMDC_MODE_HALF 2
`define LCDMDC_MODE_EN 3
`define LCDMDC_MODE_SAVE 4

// pointer register fields
`define LCDMDC_PTR_ADDR 5:0
`define LCDMDC_PTR_SUB 10:8

// drive level codes, from the positive supply downward
`define LCDMDC_LVL_VDD 2'h0
`define LCDMDC_LVL_ONE3 2'h1
`define LCDMDC_LVL_TWO3 2'h2
`define LCDMDC_LVL_VLCD 2'h3
`define LCDMDC_LVL_MID 2'h1

`endif

// ==== common/lcdmdc_pkg.sv ====
// types for the segment lcd multiplex drive control block
package lcdmdc_pkg;

    // drive mode, codes follow the mode register field
    typedef enum logic [1:0] {
        LCDMDC_STATIC,
        LCDMDC_MUX2,
        LCDMDC_MUX3,
        LCDMDC_MUX4
    } lcdmdc_mode_t;

endpackage

// ==== hdl/lcdmdc_top.sv ====
// segment lcd multiplex drive control: configuration, timebase and drive levels
`timescale 1ns/1ps
`include "lcdmdc_params.svh"

module lcdmdc_top
    import lcdmdc_pkg::*;
#(
    parameter int NUM_SEG = 40,
    parameter int POR_CYCLES = `LCDMDC_POR_WAIT_US * `LCDMDC_CLK_MHZ,
    parameter int OSC_HALF = `LCDMDC_CLK_KHZ / (2 * `LCDMDC_OSC_KHZ)
) (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic ce_in,
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    input wire logic osc_sel_in,
    input wire logic clk_pin_in,
    output logic clk_pin_out,
    output logic clk_pin_oe_n_out,
    output logic bias_bypass_out,
    output logic [7:0] backplane_outputs_out,
    output logic [2*NUM_SEG-1:0] segment_outputs_out
);

    localparam int PW = 6;
    localparam int PORW = $clog2(POR_CYCLES + 1);
    localparam int OSCW = $clog2(OSC_HALF + 1);

    // elaboration check of parameters
    if (NUM_SEG < 1 || NUM_SEG > 63 || POR_CYCLES < 1 || OSC_HALF < 1) begin : g_bad_param
        $error("lcdmdc_top: parameter out of range");
    end

    // number of active backplanes for a drive mode
    function automatic logic [2:0] act_bp(input lcdmdc_mode_t m);
        act_bp = 3'({1'b0, m} + 3'h1);
    endfunction

    // clock ticks in one half of a slot
    function automatic logic [11:0] half_slot(input lcdmdc_mode_t m, input logic save);
        logic [11:0] div;
        div = save ? `LCDMDC_FRAME_DIV_SAVE : `LCDMDC_FRAME_DIV_NORMAL;
        half_slot = div / {8'h00, act_bp(m), 1'b0};
    endfunction

    // ram row carried by backplane k
    function automatic logic [1:0] bp_row(input int k, input lcdmdc_mode_t m);
        logic [1:0] kk;
        kk = 2'(k);
        unique case (m)
            LCDMDC_STATIC: bp_row = 2'h0;
            LCDMDC_MUX2: bp_row = {1'b0, kk[0]};
            LCDMDC_MUX3: bp_row = (kk == 2'h3) ? 2'h1 : kk;
            LCDMDC_MUX4: bp_row = kk;
        endcase
    endfunction

    // true when any output in a vector shows a given level
    function automatic logic has_level(input logic [2*NUM_SEG+7:0] v, input logic [1:0] lvl);
        has_level = 1'b0;
        for (int i = 0; i < NUM_SEG + 4; i++) begin
            if (v[2*i +: 2] == lvl) begin
                has_level = 1'b1;
            end
        end
    endfunction

    lcdmdc_mode_t mode_q;
    logic half_q, en_q, save_q;
    logic [1:0] blink_q;
    logic bank_in_q, bank_out_q;
    logic [PW-1:0] ptr_q;
    logic [2:0] sub_q;
    logic [3:0] mem_q [NUM_SEG];
    logic [PORW-1:0] por_cnt_q;
    logic por_done_q;
    logic [OSCW-1:0] osc_cnt_q;
    logic osc_q, osc_prev_q, ext_prev_q;
    logic tick;
    logic [11:0] ph_cnt_q;
    logic phase_q;
    logic [1:0] slot_q;
    logic mode_wr, data_wr, frame_end;
    logic [1:0] row_off;

    assign mode_wr = wr_in && addr_in == `LCDMDC_REG_MODE;
    assign data_wr = wr_in && addr_in == `LCDMDC_REG_DATA;
    assign row_off = (bank_out_q && mode_q <= LCDMDC_MUX2) ? 2'h2 : 2'h0;

    // mode-set register, power-on default four backplanes with third bias
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            mode_q <= LCDMDC_MUX4;
            half_q <= 1'b0;
            en_q <= 1'b0;
            save_q <= 1'b0;
        end else if (ce_in && mode_wr) begin
            mode_q <= lcdmdc_mode_t'(wr_data_in[`LCDMDC_MODE_DRIVE]);
            half_q <= wr_data_in[`LCDMDC_MODE_HALF];
            en_q <= wr_data_in[`LCDMDC_MODE_EN];
            save_q <= wr_data_in[`LCDMDC_MODE_SAVE];
        end
    end

    // blink and bank selectors, cleared at power-on
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            blink_q <= 2'h0;
            bank_in_q <= 1'b0;
            bank_out_q <= 1'b0;
        end else if (ce_in && wr_in) begin
            if (addr_in == `LCDMDC_REG_BLINK) begin
                blink_q <= wr_data_in[1:0];
            end
            if (addr_in == `LCDMDC_REG_BANK) begin
                bank_in_q <= wr_data_in[0];
                bank_out_q <= wr_data_in[1];
            end
        end
    end

    // data pointer and subaddress counter, auto-incremented by data writes
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            ptr_q <= '0;
            sub_q <= 3'h0;
        end else if (ce_in && wr_in && addr_in == `LCDMDC_REG_POINTER) begin
            ptr_q <= wr_data_in[`LCDMDC_PTR_ADDR];
            sub_q <= wr_data_in[`LCDMDC_PTR_SUB];
        end else if (ce_in && data_wr) begin
            if (ptr_q == PW'(NUM_SEG - 1)) begin
                ptr_q <= '0;
                sub_q <= 3'(sub_q + 3'h1);
            end else begin
                ptr_q <= PW'(ptr_q + 1'b1);
            end
        end
    end

    // display memory, one nibble per segment column
    always_ff @(posedge clock_in) begin
        if (ce_in && data_wr && ptr_q < PW'(NUM_SEG)) begin
            mem_q[ptr_q] <= wr_data_in[3:0];
        end
    end

    // power-on settle counter, seen by software as a ready flag
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            por_cnt_q <= '0;
            por_done_q <= 1'b0;
        end else if (ce_in && !por_done_q) begin
            por_cnt_q <= PORW'(por_cnt_q + 1'b1);
            por_done_q <= (por_cnt_q == PORW'(POR_CYCLES - 1));
        end
    end

    // register read port, answer one cycle after the strobe
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            rd_data_out <= '0;
        end else if (ce_in && rd_in) begin
            unique case (addr_in)
                `LCDMDC_REG_MODE: rd_data_out <= {27'h0, save_q, en_q, half_q, mode_q};
                `LCDMDC_REG_BLINK: rd_data_out <= {30'h0, blink_q};
                `LCDMDC_REG_BANK: rd_data_out <= {30'h0, bank_out_q, bank_in_q};
                `LCDMDC_REG_POINTER: rd_data_out <= {21'h0, sub_q, 2'h0, ptr_q};
                `LCDMDC_REG_STATUS: rd_data_out <= {27'h0, osc_sel_in, phase_q, slot_q, por_done_q};
                default: rd_data_out <= '0;
            endcase
        end
    end

    // internal oscillator divider and clock pin direction
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            osc_cnt_q <= '0;
            osc_q <= 1'b0;
            clk_pin_out <= 1'b0;
            clk_pin_oe_n_out <= 1'b1;
        end else if (ce_in) begin
            clk_pin_oe_n_out <= osc_sel_in;
            if (osc_cnt_q == OSCW'(OSC_HALF - 1)) begin
                osc_cnt_q <= '0;
                osc_q <= !osc_q;
            end else begin
                osc_cnt_q <= OSCW'(osc_cnt_q + 1'b1);
            end
            clk_pin_out <= osc_q;
        end
    end

    // edge history of both clock sources
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            osc_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
        end else if (ce_in) begin
            osc_prev_q <= osc_q;
            ext_prev_q <= clk_pin_in;
        end
    end

    // one drive-clock tick from the selected source
    assign tick = osc_sel_in ? (clk_pin_in && !ext_prev_q) : (osc_q && !osc_prev_q);
    assign frame_end = tick && phase_q && ph_cnt_q == 12'(half_slot(mode_q, save_q) - 12'h1)
        && slot_q == 2'(act_bp(mode_q) - 3'h1);

    // frame divider: each slot is two inverted halves, one slot per active backplane
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            ph_cnt_q <= 12'h0;
            phase_q <= 1'b0;
            slot_q <= 2'h0;
        end else if (ce_in && mode_wr) begin
            ph_cnt_q <= 12'h0;
            phase_q <= 1'b0;
            slot_q <= 2'h0;
        end else if (ce_in && tick) begin
            if (ph_cnt_q == 12'(half_slot(mode_q, save_q) - 12'h1)) begin
                ph_cnt_q <= 12'h0;
                phase_q <= !phase_q;
                if (phase_q) begin
                    slot_q <= frame_end ? 2'h0 : 2'(slot_q + 2'h1);
                end
            end else begin
                ph_cnt_q <= 12'(ph_cnt_q + 12'h1);
            end
        end
    end

    // middle divider resistor bypass for half bias
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            bias_bypass_out <= 1'b0;
        end else if (ce_in) begin
            bias_bypass_out <= half_q && mode_q != LCDMDC_STATIC;
        end
    end

    // backplane drive levels
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            backplane_outputs_out <= '0;
        end else if (ce_in) begin
            for (int k = 0; k < 4; k++) begin
                if (!en_q) begin
                    backplane_outputs_out[2*k +: 2] <= `LCDMDC_LVL_VDD;
                end else if (bp_row(k, mode_q) == slot_q) begin
                    backplane_outputs_out[2*k +: 2] <= phase_q ? `LCDMDC_LVL_VLCD
                        : `LCDMDC_LVL_VDD;
                end else if (half_q) begin
                    backplane_outputs_out[2*k +: 2] <= `LCDMDC_LVL_MID;
                end else begin
                    backplane_outputs_out[2*k +: 2] <= phase_q ? `LCDMDC_LVL_ONE3
                        : `LCDMDC_LVL_TWO3;
                end
            end
        end
    end

    // segment drive levels from the row of the current slot
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            segment_outputs_out <= '0;
        end else if (ce_in) begin
            for (int s = 0; s < NUM_SEG; s++) begin
                if (!en_q) begin
                    segment_outputs_out[2*s +: 2] <= `LCDMDC_LVL_VDD;
                end else if (mem_q[s][2'(slot_q + row_off)]) begin
                    segment_outputs_out[2*s +: 2] <= phase_q ? `LCDMDC_LVL_VDD
                        : `LCDMDC_LVL_VLCD;
                end else if (mode_q == LCDMDC_STATIC) begin
                    segment_outputs_out[2*s +: 2] <= phase_q ? `LCDMDC_LVL_VLCD
                        : `LCDMDC_LVL_VDD;
                end else if (half_q) begin
                    segment_outputs_out[2*s +: 2] <= `LCDMDC_LVL_MID;
                end else begin
                    segment_outputs_out[2*s +: 2] <= phase_q ? `LCDMDC_LVL_TWO3
                        : `LCDMDC_LVL_ONE3;
                end
            end
        end
    end

    // checks
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (reset_in);

    logic [12:0] frame_ticks_q;
    logic [11:0] frame_div;
    assign frame_div = save_q ? `LCDMDC_FRAME_DIV_SAVE : `LCDMDC_FRAME_DIV_NORMAL;

    // ticks counted since the frame began, for the divisor check
    always_ff @(posedge clock_in or posedge reset_in) begin
        if (reset_in) begin
            frame_ticks_q <= 13'h0;
        end else if (ce_in && (mode_wr || frame_end)) begin
            frame_ticks_q <= 13'h0;
        end else if (ce_in && tick) begin
            frame_ticks_q <= 13'(frame_ticks_q + 13'h1);
        end
    end

    AST_DARK_UNTIL_ENABLED:
    assert property (ce_in && !en_q |=> backplane_outputs_out == '0 && segment_outputs_out == '0)
        else $error("outputs not at supply level while display disabled");
    AST_RESET_MODE:
    assert property ($past(reset_in) |-> mode_q == LCDMDC_MUX4 && !half_q && !en_q)
        else $error("reset drive configuration wrong");
    AST_RESET_BANKS:
    assert property ($past(reset_in) |-> blink_q == 2'h0 && !bank_in_q && !bank_out_q)
        else $error("reset blink or bank selectors wrong");
    AST_RESET_POINTER:
    assert property ($past(reset_in) |-> ptr_q == '0 && sub_q == 3'h0)
        else $error("reset pointer or subaddress not zero");
    AST_CLK_PIN_DIR:
    assert property (ce_in |=> clk_pin_oe_n_out == $past(osc_sel_in))
        else $error("clock pin direction does not follow select");
    AST_FRAME_DIVISOR:
    assert property (ce_in && frame_end && !mode_wr |-> frame_ticks_q == 13'(frame_div - 12'h1))
        else $error("frame length differs from divisor");
    AST_SLOT_RANGE:
    assert property ({1'b0, slot_q} < act_bp(mode_q))
        else $error("slot beyond active backplanes");
    AST_STATIC_LEVELS:
    assert property (ce_in && en_q && mode_q == LCDMDC_STATIC |=>
        !has_level({segment_outputs_out, backplane_outputs_out}, `LCDMDC_LVL_ONE3)
        && !has_level({segment_outputs_out, backplane_outputs_out}, `LCDMDC_LVL_TWO3))
        else $error("static mode uses an intermediate level");
    // bypass was computed from the mode held in the cycle before, so compare against that
    AST_HALF_THREE_LEVELS:
    assert property (ce_in && half_q |=> bias_bypass_out == ($past(mode_q) != LCDMDC_STATIC)
        && !has_level({segment_outputs_out, backplane_outputs_out}, `LCDMDC_LVL_TWO3))
        else $error("half bias shows fourth level or no bypass");
    AST_BP_MIRROR:
    assert property (ce_in && mode_q == LCDMDC_MUX3 && !mode_wr |=>
        backplane_outputs_out[7:6] == backplane_outputs_out[3:2])
        else $error("fourth backplane differs from second in three-backplane mode");
    AST_SEG_ON_SLOT:
    assert property (ce_in && en_q && !phase_q && mode_q == LCDMDC_MUX4
        && mem_q[0][slot_q] |=> segment_outputs_out[1:0] == `LCDMDC_LVL_VLCD)
        else $error("on pixel not driven in its slot");

endmodule // lcdmdc_top

// ==== testbench/lcdmdc_panel.sv ====
// lcd panel model that records which drive levels reach its electrodes
`timescale 1ns/1ps
module lcdmdc_panel (
    input wire logic clock_in,
    input wire logic clear_in,
    input wire logic [7:0] backplane_in,
    input wire logic [1:0] segment_in,
    output logic [3:0] levels_out
);
    logic [3:0] seen;

    // levels present this cycle on the four backplanes and the watched segment
    always_comb begin
        seen = 4'h0;
        for (int k = 0; k < 4; k++) begin
            seen[backplane_in[2*k+:2]] = 1'b1;
        end
        seen[segment_in] = 1'b1;
    end

    // accumulate levels until the bench clears the record
    always_ff @(posedge clock_in) begin
        if (clear_in) begin
            levels_out <= 4'h0;
        end else begin
            levels_out <= levels_out | seen;
        end
    end
endmodule // lcdmdc_panel

// ==== testbench/lcdmdc_top_test.sv ====
// self-checking bench for the lcd multiplex drive control block
`timescale 1ns/1ps
`include "lcdmdc_params.svh"
module lcdmdc_top_test;
    logic clock_in, reset_in, wr_in, rd_in, osc_sel_in, clk_pin_in, ext_run, clear, ce;
    logic [7:0] addr_in, bp;
    logic [31:0] wr_data_in, rd_data_out, rv;
    logic clk_pin_out, clk_pin_oe_n_out, bias_bypass_out;
    logic [79:0] seg;
    logic [3:0] levels;
    int bad_count = 0;
    int checked = 0;
    int cycles = 0;

    lcdmdc_top #(.POR_CYCLES(20), .OSC_HALF(2)) uut (.clock_in(clock_in), .reset_in(reset_in),
        .ce_in(ce), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
        .rd_data_out(rd_data_out), .osc_sel_in(osc_sel_in), .clk_pin_in(clk_pin_in),
        .clk_pin_out(clk_pin_out), .clk_pin_oe_n_out(clk_pin_oe_n_out),
        .bias_bypass_out(bias_bypass_out), .backplane_outputs_out(bp), .segment_outputs_out(seg));

    lcdmdc_panel panel (.clock_in(clock_in), .clear_in(clear), .backplane_in(bp),
        .segment_in(seg[1:0]), .levels_out(levels));

    // 125 mhz clock that never stops, far above the minimum drive clock
    initial begin
        clock_in = 1'b0;
        forever #4 clock_in = ~clock_in;
    end

    // external drive clock toggles every cycle while enabled
    always @(posedge clock_in) begin
        if (ext_run) begin
            clk_pin_in <= ~clk_pin_in;
        end
    end

    // cycle ceiling cuts a hang short
    always @(posedge clock_in) begin
        cycles++;
        if (cycles == 60000) begin
            bad_count++;
            $display("unexpected timeout after %0d cycles", cycles);
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= d;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask

    // read data appear in the cycle after the strobe and hold until the next read
    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
    endtask

    task automatic reset_test();
        int n;
        chk("backplanes", 32'h0, {24'h0, bp});
        chk("segments", 32'h0, {31'h0, |seg});
        chk("bypass", 32'h0, {31'h0, bias_bypass_out});
        // host stays off the bus until the power-on settle time has run out
        repeat (20) @(posedge clock_in);
        reg_rd(`LCDMDC_REG_MODE, rv);
        chk("mode", 32'h3, rv);
        reg_rd(8'h40, rv);
        chk("unmapped", 32'h0, rv);
        reg_rd(`LCDMDC_REG_BLINK, rv);
        chk("blink", 32'h0, rv);
        reg_rd(`LCDMDC_REG_BANK, rv);
        chk("bank", 32'h0, rv);
        reg_rd(`LCDMDC_REG_POINTER, rv);
        chk("pointer", 32'h0, rv);
        n = 0;
        rv = 32'h0;
        while (rv[0] !== 1'b1 && n < 40) begin
            reg_rd(`LCDMDC_REG_STATUS, rv);
            n++;
        end
        chk("ready", 32'h1, {31'h0, rv[0]});
        // selectors store, pointer wraps after the last column and bumps the subaddress
        reg_wr(`LCDMDC_REG_BLINK, 32'h3);
        reg_wr(`LCDMDC_REG_BANK, 32'h3);
        reg_wr(`LCDMDC_REG_POINTER, 32'h227);
        reg_wr(`LCDMDC_REG_DATA, 32'h0);
        reg_rd(`LCDMDC_REG_BLINK, rv);
        chk("blink set", 32'h3, rv);
        reg_rd(`LCDMDC_REG_BANK, rv);
        chk("bank set", 32'h3, rv);
        reg_rd(`LCDMDC_REG_POINTER, rv);
        chk("pointer wrap", 32'h300, rv);
        $display("test reset done");
    endtask

    task automatic clock_sel_test();
        int n;
        logic last;
        chk("pin drive", 32'h0, {31'h0, clk_pin_oe_n_out});
        n = 0;
        last = clk_pin_out;
        repeat (16) begin
            @(posedge clock_in);
            #1 n += (clk_pin_out !== last);
            last = clk_pin_out;
        end
        chk("osc toggles", 32'd8, n);
        // clock enable low must freeze the oscillator divider
        @(posedge clock_in);
        ce <= 1'b0;
        #1 last = clk_pin_out;
        n = 0;
        repeat (8) begin
            @(posedge clock_in);
            #1 n += (clk_pin_out !== last);
        end
        chk("frozen pin", 32'd0, n);
        @(posedge clock_in);
        ce <= 1'b1;
        osc_sel_in <= 1'b1;
        ext_run <= 1'b1;
        repeat (2) @(posedge clock_in);
        #1 chk("pin input", 32'h1, {31'h0, clk_pin_oe_n_out});
        reg_rd(`LCDMDC_REG_STATUS, rv);
        chk("status select", 32'h1, {31'h0, rv[4]});
        @(posedge clock_in);
        osc_sel_in <= 1'b0;
        repeat (2) @(posedge clock_in);
        $display("test clock select done");
    endtask

    task automatic level_test();
        logic spare_bad;
        reg_wr(`LCDMDC_REG_POINTER, 32'h0);
        reg_wr(`LCDMDC_REG_DATA, 32'h5);
        for (int m = 0; m < 4; m++) begin
            for (int h = 0; h < 2; h++) begin
                reg_wr(`LCDMDC_REG_MODE, {27'h0, 2'b11, h[0], m[1:0]});
                clear <= 1'b1;
                @(posedge clock_in);
                clear <= 1'b0;
                spare_bad = 1'b0;
                repeat (2000) begin
                    @(posedge clock_in);
                    #1 if (m == 1 && bp[7:4] !== bp[3:0]) spare_bad = 1'b1;
                    if (m == 2 && bp[7:6] !== bp[3:2]) spare_bad = 1'b1;
                    if (m == 0 && bp !== {4{bp[1:0]}}) spare_bad = 1'b1;
                end
                chk("spare backplanes", 32'h0, {31'h0, spare_bad});
                chk("levels", (m == 0) ? 32'h9 : (h ? 32'hb : 32'hf), {28'h0, levels});
                chk("bypass", {31'h0, h == 1 && m != 0}, {31'h0, bias_bypass_out});
            end
        end
        reg_wr(`LCDMDC_REG_MODE, 32'h3);
        repeat (3) @(posedge clock_in);
        #1 chk("off backplanes", 32'h0, {24'h0, bp});
        chk("off segments", 32'h0, {31'h0, |seg});
        $display("test levels done");
    endtask

    // step until backplane 0 does or does not show the selected level
    task automatic wait_bp0(input bit eq, inout int t, inout logic bad);
        while ((bp[1:0] === 2'h3) != eq && t < 30000) begin
            @(posedge clock_in);
            #1 t++;
            if (bp[1:0] === 2'h3 && seg[1:0] !== 2'h0) bad = 1'b1;
            if (bp[3:2] === 2'h3 && seg[1:0] !== 2'h2) bad = 1'b1;
        end
    endtask

    task automatic measure(input logic [31:0] mode, input int exp);
        int t;
        logic bad;
        bad = 1'b0;
        t = 0;
        reg_wr(`LCDMDC_REG_MODE, mode);
        // let the restarted frame reach the outputs before looking
        repeat (2) @(posedge clock_in);
        #1 wait_bp0(1'b1, t, bad);
        t = 0;
        wait_bp0(1'b0, t, bad);
        wait_bp0(1'b1, t, bad);
        chk("frame cycles", exp, t);
        chk("segment rows", 32'h0, {31'h0, bad});
    endtask

    task automatic frame_test();
        measure(32'h0b, 2880 * 4);
        @(posedge clock_in);
        osc_sel_in <= 1'b1;
        ext_run <= 1'b1;
        measure(32'h1b, 480 * 2);
        $display("test frame done");
    endtask

    initial begin
        reset_in = 1'b1;
        wr_in = 1'b0;
        rd_in = 1'b0;
        addr_in = 8'h00;
        wr_data_in = 32'h0;
        osc_sel_in = 1'b0;
        clk_pin_in = 1'b0;
        ext_run = 1'b0;
        clear = 1'b1;
        ce = 1'b1;
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        clear <= 1'b0;
        @(posedge clock_in);
        #1 reset_test();
        clock_sel_test();
        level_test();
        frame_test();
        stop_test();
    end
endmodule // lcdmdc_top_test
